// ---- ccd_cfg.svh ----
// timing counts, frame geometry and flag positions for the ccd readout controller
// assumes a single 200 MHz reference clock; included by bare name
`ifndef CCD_CFG_SVH
`define CCD_CFG_SVH

`define CLK_MHZ         200
`define NS2CYC(ns)      ((((ns) * `CLK_MHZ) + 999) / 1000)

`define PIX_NS          250
`define PIX_MIN_NS      100
`define SETTLE_NS       1000
`define SETTLE_MIN_NS   500
`define VPULSE_NS       2000
`define RST_NS          20

`define SAMPLE_POS      10
`define FIFO_DEPTH      8

`define COLS            796
`define ROWS            520
`define LEAD_DUMMY      10
`define LEAD_DARK       4
`define TRAIL_DARK      12
`define TRAIL_DUMMY     2
`define DARK_LINES      4

`define FLG_DUMMY       0
`define FLG_DARK        1
`define FLG_DLINE       2
`define FLG_SUSPECT     3
`define FLG_W           4

`endif

// ---- ccd_fifo.sv ----
// flip-flop fifo with valid/ready on both sides
// assumes one clock and a synchronous active low reset
`timescale 1ns/1ps
module ccd_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_data,
  input  wire logic         i_valid,
  output logic              o_ready,
  output logic [W-1:0]      o_data,
  output logic              o_valid,
  input  wire logic         i_ready
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;

  if (D < 2 || (1 << AW) != D) begin : g_chk
    $error("ccd_fifo depth must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } fifo_s;

  fifo_s s_r;
  fifo_s s_nxt;
  logic  wr;
  logic  rd;

  assign o_ready = (s_r.cnt != (AW+1)'(D));
  assign o_valid = (s_r.cnt != '0);
  assign o_data  = s_r.mem[s_r.rp];
  assign wr      = i_valid && o_ready;
  assign rd      = o_valid && i_ready;

  always_comb begin
    s_nxt = s_r;
    if (wr) begin
      s_nxt.mem[s_r.wp] = i_data;
      s_nxt.wp          = s_r.wp + 1'b1;
    end
    if (rd) begin
      s_nxt.rp = s_r.rp + 1'b1;
    end
    if (wr && !rd) begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end else if (rd && !wr) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

// ---- ccd_pkg.sv ----
// types shared by the ccd readout controller
// assumes nothing beyond the config header
package ccd_pkg;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_INTEG  = 3'h1,
    ST_V1     = 3'h3,
    ST_V2     = 3'h2,
    ST_VWAIT  = 3'h6,
    ST_SETTLE = 3'h7,
    ST_HSHIFT = 3'h5
  } seq_state_e;

  typedef logic [9:0] pos_t;

endpackage

// ---- ccd_readout_ctrl.sv ----
// timing generator and video capture for a full-frame two-phase ccd sensor
// assumes the video adc word is synchronous to i_ref_clk and settled at the sample point
//
// Overview of operation
// - pulse the reset clock only after the current pixel has been sampled.
// - both vertical phases stay low through integration.
// - line moves on vertical phase two falling while horizontal phase one is high.
// - horizontal phases toggle alternately and in complement during shifting.
// - pixel period never under 100 ns, nominal 250 ns.
// - reset clock runs continuously, also when no pixels shift.
// - at least 0.5 us settling, nominal 1 us, before the first horizontal shift.
`timescale 1ns/1ps
`include "ccd_cfg.svh"
module ccd_readout_ctrl #(
  parameter int VID_W      = 12,
  parameter int PIX_CYC    = `NS2CYC(`PIX_NS),
  parameter int SETTLE_CYC = `NS2CYC(`SETTLE_NS),
  parameter int VPULSE_CYC = `NS2CYC(`VPULSE_NS),
  parameter int RST_CYC    = `NS2CYC(`RST_NS),
  parameter int FIFO_D     = `FIFO_DEPTH
) (
  input  wire logic               i_ref_clk,
  input  wire logic               i_rst_n,
  input  wire logic               i_start,
  input  wire logic [31:0]        i_int_len,
  input  wire logic [VID_W-1:0]   i_video,
  input  wire logic               i_pix_ready,
  output logic                    o_vertical_phase_one,
  output logic                    o_vertical_phase_two,
  output logic                    o_horizontal_phase_one,
  output logic                    o_horizontal_phase_two,
  output logic                    o_reset_gate,
  output logic [VID_W-1:0]        o_pix_data,
  output logic [`FLG_W-1:0]       o_pix_flags,
  output logic                    o_pix_valid,
  output logic                    o_busy,
  output logic                    o_frame_done
);
  // ****************************************************************
  // timing constants
  // ****************************************************************
  localparam int MIN_CYC = `NS2CYC(`PIX_MIN_NS);
  localparam int HALF    = PIX_CYC / 2;
  localparam int DW      = VID_W + `FLG_W;
  localparam int HI_CYC  = PIX_CYC - HALF;
  localparam int SET_MIN = `NS2CYC(`SETTLE_MIN_NS);

  if (PIX_CYC < MIN_CYC || PIX_CYC > 255 || `SAMPLE_POS + RST_CYC >= HALF - 1 ||
      SETTLE_CYC < 1 || SETTLE_CYC > 65535 || VPULSE_CYC < 1 || VPULSE_CYC > 65535)
  begin : g_chk
    $error("ccd_readout_ctrl timing parameters out of range");
  end

  localparam logic [7:0]  PC_LAST  = 8'(PIX_CYC - 1);
  localparam logic [7:0]  PC_HALF  = 8'(HALF - 1);
  localparam logic [7:0]  PC_SAMP  = 8'(`SAMPLE_POS);
  localparam logic [7:0]  PC_REND  = 8'(`SAMPLE_POS + RST_CYC);
  localparam logic [15:0] VP_LAST  = 16'(VPULSE_CYC - 1);
  localparam logic [15:0] ST_LAST  = 16'(SETTLE_CYC - 1);
  localparam logic [9:0]  COLS     = 10'(`COLS);
  localparam logic [9:0]  ROW_LAST = 10'(`ROWS - 1);

  // ****************************************************************
  // pixel classification
  // ****************************************************************
  function automatic logic [`FLG_W-1:0] pix_flags(input ccd_pkg::pos_t row,
                                                  input ccd_pkg::pos_t col);
    logic [`FLG_W-1:0] f;
    logic              dl;
    f  = '0;
    dl = (row < 10'(`DARK_LINES)) || (row >= 10'(`ROWS - `DARK_LINES));
    f[`FLG_DLINE] = dl;
    if (col < 10'(`LEAD_DUMMY) || col >= 10'(`COLS - `TRAIL_DUMMY)) begin
      f[`FLG_DUMMY] = 1'b1;
    end
    if ((col >= 10'(`LEAD_DUMMY) && col < 10'(`LEAD_DUMMY + `LEAD_DARK)) ||
        (col >= 10'(`COLS - `TRAIL_DUMMY - `TRAIL_DARK) &&
         col < 10'(`COLS - `TRAIL_DUMMY))) begin
      f[`FLG_DARK] = 1'b1;
    end
    // dark border beside image, and leading dummies, are not clean references
    f[`FLG_SUSPECT] = (col == 10'(`LEAD_DUMMY + `LEAD_DARK - 1)) ||
                      (col == 10'(`COLS - `TRAIL_DUMMY - `TRAIL_DARK)) ||
                      (row == 10'(`DARK_LINES - 1)) ||
                      (row == 10'(`ROWS - `DARK_LINES)) ||
                      (col < 10'(`LEAD_DUMMY));
    return f;
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    ccd_pkg::seq_state_e st;
    logic [15:0]         ph;
    logic [7:0]          pc;
    ccd_pkg::pos_t       row;
    ccd_pkg::pos_t       col;
    logic [31:0]         ic;
    logic                pend;
    logic                v1;
    logic                v2;
    logic                h1;
    logic                h2;
    logic                rg;
    logic                busy;
    logic                done;
    logic [VID_W-1:0]    dat;
    logic [`FLG_W-1:0]   flg;
    logic                ov;
  } ctrl_s;

  ctrl_s            s_r;
  ctrl_s            s_nxt;
  logic             push;
  logic             fifo_rdy;
  logic             fifo_ov;
  logic [DW-1:0]    fifo_in;
  logic [DW-1:0]    fifo_out;
  logic             take;

  assign push    = s_r.pend && (s_r.pc == PC_SAMP);
  assign fifo_in = {pix_flags(s_r.row, s_r.col), ~i_video};
  assign take    = fifo_ov && (!s_r.ov || i_pix_ready);

  ccd_fifo #(
    .W (DW),
    .D (FIFO_D)
  ) u_fifo (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_data    (fifo_in),
    .i_valid   (push),
    .o_ready   (fifo_rdy),
    .o_data    (fifo_out),
    .o_valid   (fifo_ov),
    .i_ready   (!s_r.ov || i_pix_ready)
  );

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_comb begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    s_nxt.pc   = (s_r.pc == PC_LAST) ? 8'h00 : s_r.pc + 8'h01;
    // free-running reset pulse right after the sample point
    s_nxt.rg   = (s_r.pc >= PC_SAMP) && (s_r.pc < PC_REND);
    if (s_r.pc == PC_HALF) begin
      // shift only when the fifo can take the coming sample
      s_nxt.h2 = (s_r.st == ccd_pkg::ST_HSHIFT) && fifo_rdy && (s_r.col < COLS)
                 && !s_r.pend;
    end else if (s_r.pc == PC_LAST && s_r.h2) begin
      s_nxt.h2   = 1'b0;
      s_nxt.pend = 1'b1;
    end
    s_nxt.h1 = !s_nxt.h2;
    if (push) begin
      s_nxt.pend = 1'b0;
      s_nxt.col  = s_r.col + 10'h001;
    end
    case (s_r.st)
      ccd_pkg::ST_IDLE: begin
        if (i_start) begin
          s_nxt.st   = ccd_pkg::ST_INTEG;
          s_nxt.ic   = i_int_len;
          s_nxt.busy = 1'b1;
          s_nxt.row  = '0;
        end
      end
      ccd_pkg::ST_INTEG: begin
        s_nxt.v1 = 1'b0;
        s_nxt.v2 = 1'b0;
        if (s_r.ic == 32'h0000_0000) begin
          s_nxt.st = ccd_pkg::ST_V1;
          s_nxt.v1 = 1'b1;
          s_nxt.ph = '0;
        end else begin
          s_nxt.ic = s_r.ic - 32'h0000_0001;
        end
      end
      ccd_pkg::ST_V1: begin
        s_nxt.ph = s_r.ph + 16'h0001;
        if (s_r.ph == VP_LAST) begin
          s_nxt.st = ccd_pkg::ST_V2;
          s_nxt.v1 = 1'b0;
          s_nxt.v2 = 1'b1;
          s_nxt.ph = '0;
        end
      end
      ccd_pkg::ST_V2: begin
        s_nxt.ph = s_r.ph + 16'h0001;
        if (s_r.ph == VP_LAST) begin
          s_nxt.st = ccd_pkg::ST_VWAIT;
          s_nxt.v2 = 1'b0;
          s_nxt.ph = '0;
        end
      end
      ccd_pkg::ST_VWAIT: begin
        s_nxt.ph = s_r.ph + 16'h0001;
        if (s_r.ph == VP_LAST) begin
          s_nxt.st = ccd_pkg::ST_SETTLE;
          s_nxt.ph = '0;
        end
      end
      ccd_pkg::ST_SETTLE: begin
        s_nxt.ph = s_r.ph + 16'h0001;
        if (s_r.ph == ST_LAST) begin
          s_nxt.st  = ccd_pkg::ST_HSHIFT;
          s_nxt.col = '0;
        end
      end
      ccd_pkg::ST_HSHIFT: begin
        if (s_r.col == COLS && !s_r.pend && !s_r.h2) begin
          s_nxt.ph = '0;
          if (s_r.row == ROW_LAST) begin
            s_nxt.st   = ccd_pkg::ST_IDLE;
            s_nxt.busy = 1'b0;
            s_nxt.done = 1'b1;
          end else begin
            s_nxt.st  = ccd_pkg::ST_V1;
            s_nxt.row = s_r.row + 10'h001;
            s_nxt.v1  = 1'b1;
          end
        end
      end
      default: begin
        s_nxt.st = ccd_pkg::ST_IDLE;
      end
    endcase
    if (take) begin
      s_nxt.dat = fifo_out[VID_W-1:0];
      s_nxt.flg = fifo_out[DW-1:VID_W];
      s_nxt.ov  = 1'b1;
    end else if (i_pix_ready) begin
      s_nxt.ov = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      s_r    <= '0;
      s_r.h1 <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_vertical_phase_one   = s_r.v1;
  assign o_vertical_phase_two   = s_r.v2;
  assign o_horizontal_phase_one = s_r.h1;
  assign o_horizontal_phase_two = s_r.h2;
  assign o_reset_gate           = s_r.rg;
  assign o_pix_data             = s_r.dat;
  assign o_pix_flags            = s_r.flg;
  assign o_pix_valid            = s_r.ov;
  assign o_busy                 = s_r.busy;
  assign o_frame_done           = s_r.done;

  // ****************************************************************
  // checks
  // ****************************************************************
  logic [7:0] gap_r;
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      gap_r <= 8'hff;
    end else if ($fell(s_r.h2)) begin
      gap_r <= 8'h01;
    end else if (gap_r != 8'hff) begin
      gap_r <= gap_r + 8'h01;
    end
  end

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  property p_rst_after_sample;
    $rose(s_r.rg) |-> $past(s_r.pc) == PC_SAMP && !s_r.h2;
  endproperty
  a_rst_after_sample: assert property (p_rst_after_sample)
    else $error("reset gate not right after sample point");

  property p_vert_low_integ;
    s_r.st == ccd_pkg::ST_INTEG |-> !s_r.v1 && !s_r.v2;
  endproperty
  a_vert_low_integ: assert property (p_vert_low_integ)
    else $error("vertical phase high during integration");

  property p_h1_on_v2_fall;
    $fell(s_r.v2) |-> s_r.h1 && $past(s_r.h1);
  endproperty
  a_h1_on_v2_fall: assert property (p_h1_on_v2_fall)
    else $error("horizontal phase one low at line transfer");

  property p_h_complement;
    $rose(s_r.h2) |-> !s_r.h1 ##HI_CYC ($fell(s_r.h2) && s_r.h1);
  endproperty
  a_h_complement: assert property (p_h_complement)
    else $error("horizontal phases not complementary half periods");

  property p_pix_period;
    $fell(s_r.h2) |-> gap_r >= 8'(MIN_CYC);
  endproperty
  a_pix_period: assert property (p_pix_period)
    else $error("pixel period shorter than minimum");

  property p_rst_continuous;
    $rose(s_r.rg) |-> ##PIX_CYC $rose(s_r.rg);
  endproperty
  a_rst_continuous: assert property (p_rst_continuous)
    else $error("reset gate missed a period");

  property p_settle;
    $fell(s_r.v2) |-> not (##[1:SET_MIN] $rose(s_r.h2));
  endproperty
  a_settle: assert property (p_settle)
    else $error("horizontal shift before settling");

  property p_line_len;
    push |-> s_r.col < COLS && s_r.st == ccd_pkg::ST_HSHIFT ##1 s_r.col <= COLS;
  endproperty
  a_line_len: assert property (p_line_len)
    else $error("pixel captured outside its line");

  c_frame_done: cover property (s_r.done);
  c_stall: cover property (s_r.st == ccd_pkg::ST_HSHIFT && !fifo_rdy);
  c_dark_line: cover property (push && fifo_in[DW-1-(`FLG_W-1-`FLG_DLINE)]);
endmodule

// ---- ccd_readout_ctrl_tb.sv ----
// self-checking bench for the ccd readout controller at default timing
// assumes the sensor model file and the config header are compiled alongside
`timescale 1ns/1ps
`include "ccd_cfg.svh"
module ccd_readout_ctrl_tb;
  // ************************************************************
  // clock, design and sensor
  // ************************************************************
  localparam int VID_W = 12;
  localparam int PIX   = 50;
  logic                     i_ref_clk = 1'h0;
  logic                     i_rst_n;
  logic                     i_start;
  logic                     i_pix_ready;
  logic [31:0]              i_int_len;
  logic [VID_W-1:0]         video;
  logic                     v1, v2, h1, h2, rg, pix_valid, busy, frame_done;
  logic [VID_W-1:0]         pix_data;
  logic [`FLG_W-1:0]        pix_flags;
  logic                     h2_q = 1'h0;
  logic                     rg_q = 1'h0;
  logic [VID_W+`FLG_W-1:0]  q[$];
  int                       n_errors = 0;
  int                       checks = 0;
  int                       lines, model_err;
  int                       h2_falls = 0;
  int                       rg_rises = 0;

  always #2.5 i_ref_clk = ~i_ref_clk;

  ccd_readout_ctrl dut (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_start(i_start),
    .i_int_len(i_int_len), .i_video(video), .i_pix_ready(i_pix_ready),
    .o_vertical_phase_one(v1), .o_vertical_phase_two(v2),
    .o_horizontal_phase_one(h1), .o_horizontal_phase_two(h2),
    .o_reset_gate(rg), .o_pix_data(pix_data), .o_pix_flags(pix_flags),
    .o_pix_valid(pix_valid), .o_busy(busy), .o_frame_done(frame_done)
  );

  ccd_sensor_model sensor (
    .i_vertical_phase_one(v1), .i_vertical_phase_two(v2),
    .i_horizontal_phase_one(h1), .i_horizontal_phase_two(h2),
    .i_reset_gate(rg), .o_video(video), .o_lines(lines), .o_err_cnt(model_err)
  );

  always @(posedge i_ref_clk) begin
    h2_q <= h2;
    rg_q <= rg;
    if (h2_q && !h2) h2_falls++;
    if (!rg_q && rg) rg_rises++;
    if (pix_valid && i_pix_ready) q.push_back({pix_data, pix_flags});
  end

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic step();
    @(posedge i_ref_clk);
    #1;
  endtask

  task automatic expect_pix(input int row, input int col);
    int                      n;
    logic [`FLG_W-1:0]       f;
    logic [VID_W+`FLG_W-1:0] w;
    n = 0;
    while (q.size() == 0 && n < 2000) begin
      n++;
      step();
    end
    f[0] = col < 10 || col >= 794;
    f[1] = (col >= 10 && col < 14) || (col >= 782 && col < 794);
    f[2] = row < 4 || row >= 516;
    f[3] = col < 10 || col == 13 || col == 782 || row == 3 || row == 516;
    if (q.size() == 0) begin
      check(32'h0000_0000, 32'h0000_0001);
    end else begin
      w = q.pop_front();
      check(w, {2'(row), 10'(col), f});
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    repeat (5) step();
    check({v1, v2, h1, h2, rg, pix_valid, busy, frame_done}, 8'h20);
    i_rst_n = 1'h1;
    rg_rises = 0;
    repeat (4 * PIX) step();
    check(rg_rises, 4);
    check(busy, 1'h0);
    $display("test reset done");
  endtask

  task automatic t_integ();
    int n;
    i_int_len = 32'h0000_0064;
    i_start = 1'h1;
    step();
    i_start = 1'h0;
    n = 0;
    while (!busy && n < 4) begin
      n++;
      step();
    end
    n = 0;
    while (!v1 && n < 1000) begin
      check(v2, 1'h0);
      n++;
      step();
    end
    check(n, 101);
    $display("test integration done");
  endtask

  task automatic t_vertical();
    int n;
    int lo;
    int r;
    int w;
    n = 0;
    while (v1 && n < 1000) begin
      n++;
      step();
    end
    check(n, 400);
    n = 0;
    while (v2 && n < 1000) begin
      n++;
      step();
    end
    check(n, 400);
    check(h1, 1'h1);
    n = 0;
    while (!h2 && n < 1000) begin
      n++;
      step();
    end
    check(32'(n >= 600 && n <= 651), 1);
    n = 0;
    while (h2 && n < 100) begin
      check(h1, !h2);
      n++;
      step();
    end
    lo = 0;
    r = -1;
    w = 0;
    while (!h2 && lo < 100) begin
      check(h1, !h2);
      if (rg && r < 0) r = lo;
      if (rg) w++;
      lo++;
      step();
    end
    check(n + lo, PIX);
    check(r, 11);
    check(w, `NS2CYC(`RST_NS));
    $display("test vertical transfer done");
  endtask

  task automatic t_pixels();
    for (int c = 0; c < 12; c++) expect_pix(0, c);
    i_start = 1'h1;
    i_pix_ready = 1'h0;
    step();
    i_start = 1'h0;
    repeat (20 * PIX) step();
    h2_falls = 0;
    rg_rises = 0;
    repeat (10 * PIX) step();
    check(h2_falls, 0);
    check(rg_rises, 10);
    check({h1, busy, frame_done}, 3'h6);
    i_pix_ready = 1'h1;
    for (int c = 12; c < 796; c++) expect_pix(0, c);
    expect_pix(1, 0);
    check(lines, 2);
    check(model_err, 0);
    $display("test pixel stream done");
  endtask

  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial begin
    i_rst_n = 1'h0;
    i_start = 1'h0;
    i_int_len = 32'h0000_0000;
    i_pix_ready = 1'h1;
    t_reset();
    t_integ();
    t_vertical();
    t_pixels();
    complete_run();
  end

  initial begin
    #(80000 * 5);
    n_errors++;
    complete_run();
  end
endmodule

// ---- ccd_sensor_model.sv ----
// behavioural model of the full-frame two-phase sensor driven by the readout controller
// assumes phase clocks and reset gate come straight from the controller's registers
`timescale 1ns/1ps
module ccd_sensor_model #(
  parameter int VID_W = 12,
  parameter int COLS  = 796,
  parameter int ROWS  = 520
) (
  input  wire logic         i_vertical_phase_one,
  input  wire logic         i_vertical_phase_two,
  input  wire logic         i_horizontal_phase_one,
  input  wire logic         i_horizontal_phase_two,
  input  wire logic         i_reset_gate,
  output logic [VID_W-1:0]  o_video,
  output int                o_lines,
  output int                o_err_cnt
);
  // ************************************************************
  // charge transport and sense node
  // ************************************************************
  int               col = 0;
  logic [VID_W-1:0] node = '0;
  logic             v2_q = 1'h0;
  logic             h2_q = 1'h0;

  initial begin
    o_lines = 0;
    o_err_cnt = 0;
  end

  // a whole line drops into the horizontal register on the phase two fall
  always @(i_vertical_phase_two) begin
    if (v2_q === 1'h1 && i_vertical_phase_two === 1'h0) begin
      if (i_horizontal_phase_one !== 1'h1) o_err_cnt = o_err_cnt + 1;
      if (o_lines < ROWS) o_lines = o_lines + 1;
      col = 0;
    end
    v2_q = i_vertical_phase_two;
  end

  // every position, dummy and dark ones too, carries a signature of its place
  always @(i_horizontal_phase_two) begin
    if (h2_q === 1'h1 && i_horizontal_phase_two === 1'h0) begin
      // no overflow clamp: a full well is passed on unchanged
      node = VID_W'({2'(o_lines - 1), 10'(col)});
      if (col < COLS) col = col + 1;
    end
    h2_q = i_horizontal_phase_two;
  end

  always @(posedge i_reset_gate) node = '0;

  // more charge gives a lower output level
  assign o_video = ~node;
endmodule
